// ==== verilog/broadcast_device_control_ccc_decoder.sv ====
// broadcast device-control command decoder, target side
`timescale 1ns/10ps
`default_nettype none
`include "broadcast_device_control_ccc_regs.svh"
module broadcast_device_control_ccc (
	input wire logic sys_clk_in, // 25 MHz system clock
	input wire logic sys_rst_in, // synchronous reset, high
	input wire logic scl_in, // bus clock pin from host
	input wire logic sda_in, // bus data pin, input side
	output logic sda_out, // bus data drive level
	output logic sda_oe_out, // high while driving data
	input wire logic i3c_mode_in, // high in I3C Basic mode
	input wire logic pec_enable_in, // checksum function enabled
	input wire logic parity_enable_in, // parity checking enabled
	input wire logic [3:0] local_type_id_in, // own upper code
	input wire logic [2:0] host_slot_id_in, // own lower code
	output logic [31:0] data_out, // accepted payload bytes
	output logic [3:0] byte_en_out, // which payload bytes valid
	output logic devspec_out, // device-specific space selected
	output logic commit_out, // pulse: payload accepted
	output logic parity_err_out, // pulse: parity error
	output logic pec_err_out // pulse: checksum error
);
	logic start_w, stop_w, rise_w, fall_w, sda_w;
	frame_pkg::state_t state_reg, state_next;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic [7:0] crc_reg;
	logic [2:0] ams_reg;
	logic [1:0] fbi_reg, bl_reg;
	logic rss_reg;
	logic [2:0] idx_reg, cnt_reg;
	logic prev_err_reg;
	logic [7:0] byte_reg [0:3];
	logic [3:0] en_reg;

	bus_frontend bus_frontend_i (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.start_out(start_w),
		.stop_out(stop_w),
		.rise_out(rise_w),
		.fall_out(fall_w),
		.sda_out(sda_w)
	);

	//----------------------------------------
	// helper functions
	//----------------------------------------
	// odd parity over byte and T bit
	function automatic logic par_bad(input logic [7:0] b, input logic t);
		par_bad = ~(^{b, t});
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `BC_CRC_POLY) : (r << 1);
		end
		crc8 = r;
	endfunction

	//----------------------------------------
	// byte decode, named wires
	//----------------------------------------
	wire byte_done = rise_w & (bit_reg == `BC_LAST_BIT);
	wire tbit = sda_w;
	wire pe_w = parity_enable_in & par_bad(shift_reg, tbit);
	wire pec_on = pec_enable_in & i3c_mode_in; // R13
	wire addr_ok = (shift_reg == `BC_BCAST_WR) & ~prev_err_reg; // R8 R9
	wire [2:0] ams_w = shift_reg[`BC_AMS_HI:`BC_AMS_LO];
	wire ams_legal = (ams_w == `BC_AMS_UNI) | // R14
		(ams_w == `BC_AMS_MULTI) | (ams_w == `BC_AMS_ALL);
	wire [6:0] own_code = {local_type_id_in, host_slot_id_in};
	wire full_hit = shift_reg[`BC_CODE_HI:`BC_CODE_LO] == own_code;
	wire upper_hit = shift_reg[`BC_CODE_HI:`BC_TYPE_LO] == local_type_id_in;
	wire tsel_hit = (ams_reg == `BC_AMS_ALL) | // R14
		((ams_reg == `BC_AMS_MULTI) & upper_hit) |
		((ams_reg == `BC_AMS_UNI) & full_hit);
	// general space counts burst, device space uses fixed length
	wire [1:0] need_bl = rss_reg ? `BC_DEVSPEC_BL : bl_reg; // R16 R17
	wire last_data = cnt_reg[1:0] == need_bl;
	wire pec_hit = shift_reg == crc_reg;
	wire ended = start_w | stop_w; // R7
	wire plain_commit = ended & (state_reg == frame_pkg::ST_PAYLOAD) &
		~pec_on & (cnt_reg != `BC_CNT_ZERO);
	wire check_commit = byte_done & (state_reg == frame_pkg::ST_CHECK) &
		~pe_w & pec_hit;
	wire store_w = byte_done & (state_reg == frame_pkg::ST_PAYLOAD) &
		~pe_w & (idx_reg != `BC_IDX_END);
	wire pe_seen = byte_done & pe_w & ((state_reg == frame_pkg::ST_SELECT)
		| (state_reg == frame_pkg::ST_PAYLOAD)
		| (state_reg == frame_pkg::ST_CHECK));
	wire tsel_err = byte_done & (state_reg == frame_pkg::ST_TARGET) &
		(pe_w | ~tsel_hit); // R10
	wire pec_bad = byte_done & (state_reg == frame_pkg::ST_CHECK) &
		~pe_w & ~pec_hit;

	//----------------------------------------
	// frame state machine
	//----------------------------------------
	always_comb begin
		state_next = state_reg;
		if (start_w) begin
			state_next = frame_pkg::ST_ADDR; // R7
		end else if (stop_w) begin
			state_next = frame_pkg::ST_IDLE;
		end else if (byte_done) begin
			case (state_reg)
			frame_pkg::ST_ADDR: begin
				state_next = addr_ok ? frame_pkg::ST_SELECT :
					frame_pkg::ST_IGNORE; // R18
			end
			frame_pkg::ST_SELECT: begin
				state_next = (pe_w | ~ams_legal) ? frame_pkg::ST_IGNORE :
					frame_pkg::ST_TARGET; // R14
			end
			frame_pkg::ST_TARGET: begin
				// a mismatch or a parity error drops the packet, parity of the rest not checked
				state_next = (pe_w | ~tsel_hit) ? frame_pkg::ST_IGNORE :
					frame_pkg::ST_PAYLOAD; // R11 R12
			end
			frame_pkg::ST_PAYLOAD: begin
				if (pe_w) begin
					state_next = frame_pkg::ST_IGNORE;
				end else if (pec_on & last_data) begin
					state_next = frame_pkg::ST_CHECK; // R16
				end
			end
			frame_pkg::ST_CHECK: begin
				state_next = frame_pkg::ST_IGNORE;
			end
			default: begin
				state_next = state_reg;
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= frame_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	//----------------------------------------
	// bit counter and shifter
	//----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in | ended) begin
			bit_reg <= `BC_BIT_ZERO;
			shift_reg <= 8'h00;
		end else if (rise_w) begin
			if (byte_done) begin
				bit_reg <= `BC_BIT_ZERO;
			end else begin
				bit_reg <= bit_reg + 4'h1;
				shift_reg <= {shift_reg[6:0], sda_w};
			end
		end
	end

	//----------------------------------------
	// acknowledge drive on the address byte
	//----------------------------------------
	// drive from the fall after bit 8 to the fall after the ack slot
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in | ended) begin
			sda_oe_out <= 1'b0;
		end else if (fall_w) begin
			sda_oe_out <= (state_reg == frame_pkg::ST_ADDR) &
				(bit_reg == `BC_LAST_BIT) & addr_ok; // R1 R8 R9
		end
	end
	assign sda_out = 1'b0;

	//----------------------------------------
	// checksum, select fields, indices
	//----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in | start_w) begin
			crc_reg <= `BC_CRC_INIT; // R3
			ams_reg <= `BC_AMS_UNI;
			fbi_reg <= 2'h0;
			bl_reg <= 2'h0;
			rss_reg <= 1'b0;
			idx_reg <= 3'h0;
			cnt_reg <= `BC_CNT_ZERO;
		end else if (byte_done) begin
			if (state_reg == frame_pkg::ST_SELECT) begin
				crc_reg <= crc8(crc_reg, shift_reg); // R3
				ams_reg <= ams_w;
				fbi_reg <= shift_reg[`BC_FBI_HI:`BC_FBI_LO];
				bl_reg <= shift_reg[`BC_BL_HI:`BC_BL_LO];
				rss_reg <= shift_reg[`BC_RSS_BIT];
			end else if (state_reg == frame_pkg::ST_TARGET) begin
				crc_reg <= crc8(crc_reg, shift_reg);
				idx_reg <= rss_reg ? 3'h0 : {1'b0, fbi_reg}; // R15 R17
			end else if (state_reg == frame_pkg::ST_PAYLOAD) begin
				crc_reg <= crc8(crc_reg, shift_reg);
				cnt_reg <= cnt_reg + 3'h1;
				if (store_w) begin
					idx_reg <= idx_reg + 3'h1; // R15
				end
			end
		end
	end

	//----------------------------------------
	// payload holding, committed only when whole
	//----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `BC_NUM_BYTES; g++) begin : g_byte
			always_ff @(posedge sys_clk_in) begin
				if (sys_rst_in) begin
					byte_reg[g] <= 8'h00;
				end else if (store_w & (idx_reg[1:0] == 2'(g))) begin
					byte_reg[g] <= shift_reg;
				end
			end
			always_ff @(posedge sys_clk_in) begin
				if (sys_rst_in | start_w) begin
					en_reg[g] <= 1'b0;
				end else if (store_w & (idx_reg[1:0] == 2'(g))) begin
					en_reg[g] <= 1'b1;
				end
			end
		end
	endgenerate

	//----------------------------------------
	// outputs and the chained-error memory
	//----------------------------------------
	wire commit_w = plain_commit | check_commit;
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			data_out <= 32'h0000_0000;
			byte_en_out <= 4'h0;
			devspec_out <= 1'b0;
			commit_out <= 1'b0;
			parity_err_out <= 1'b0;
			pec_err_out <= 1'b0;
			prev_err_reg <= 1'b0;
		end else begin
			commit_out <= commit_w;
			if (commit_w) begin
				data_out <= {byte_reg[3], byte_reg[2], byte_reg[1], byte_reg[0]};
				byte_en_out <= en_reg;
				devspec_out <= rss_reg; // R17
			end
			parity_err_out <= pe_seen | tsel_err; // R10
			pec_err_out <= pec_bad;
			// a new error outranks the stop that would clear it
			if (pe_seen | tsel_err | pec_bad) begin
				prev_err_reg <= 1'b1; // R8 R9
			end else if (stop_w) begin
				prev_err_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verilog/broadcast_device_control_ccc_regs.svh ====
// constants of the broadcast device-control command decoder
// Operation
// R1: command works in both bus modes
// R2: host keeps I2C rate at most 1 MHz; the bench host model runs 3.125 MHz
// R3: checksum starts at start, skips broadcast address
// R4: host never uses command for non-volatile memory
// R5: host honours device-specific register restrictions
// R6: host uses command only with one-byte addressing
// R7: stop or repeat start ends command
// R8: NACK broadcast after parity error, chained
// R9: NACK broadcast after parity or checksum error
// R10: target-select mismatch reports a parity error
// R11: mismatch with good parity ignores whole packet
// R12: target-select parity error discards rest, no checksum
// R13: checksum variant only in I3C Basic mode
// R14: match select 000 full, 011 upper, 111 all
// R15: first byte index picks start, sequential after
// R16: burst length tells when checksum byte comes
// R17: space select 0 general, 1 device-specific
// R18: frame order address, select, target, payload, checksum
`ifndef BCAST_CTRL_REGS_SVH
`define BCAST_CTRL_REGS_SVH
//----------------------------------------
// framing
//----------------------------------------
`define BC_BCAST_WR 8'hfc
`define BC_LAST_BIT 4'h8
`define BC_BIT_ZERO 4'h0
//----------------------------------------
// select byte fields
//----------------------------------------
`define BC_AMS_HI 7
`define BC_AMS_LO 5
`define BC_FBI_HI 4
`define BC_FBI_LO 3
`define BC_BL_HI 2
`define BC_BL_LO 1
`define BC_RSS_BIT 0
`define BC_AMS_UNI 3'h0
`define BC_AMS_MULTI 3'h3
`define BC_AMS_ALL 3'h7
//----------------------------------------
// target byte fields
//----------------------------------------
`define BC_CODE_HI 7
`define BC_CODE_LO 1
`define BC_TYPE_LO 4
//----------------------------------------
// payload and checksum
//----------------------------------------
`define BC_IDX_END 3'h4
`define BC_CNT_ZERO 3'h0
`define BC_DEVSPEC_BL 2'h1
`define BC_NUM_BYTES 4
`define BC_CRC_POLY 8'h07
`define BC_CRC_INIT 8'h00
`endif

// ==== verilog/broadcast_device_control_ccc_pkg.sv ====
// types of the broadcast device-control command decoder
`default_nettype none
package frame_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_SELECT,
		ST_TARGET,
		ST_PAYLOAD,
		ST_CHECK,
		ST_IGNORE
	} state_t;
endpackage
`default_nettype wire

// ==== verilog/bus_frontend.sv ====
// pin synchroniser and start, stop and bit detector
`timescale 1ns/10ps
`default_nettype none
module bus_frontend (
	input wire logic sys_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset
	input wire logic scl_in, // bus clock pin
	input wire logic sda_in, // bus data pin
	output logic start_out, // start or repeat start seen
	output logic stop_out, // stop seen
	output logic rise_out, // bus clock rising edge
	output logic fall_out, // bus clock falling edge
	output logic sda_out // synchronised data level
);
	logic [2:0] scl_reg;
	logic [2:0] sda_reg;

	//----------------------------------------
	// two-flop sync plus one history stage
	//----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			scl_reg <= 3'h7;
			sda_reg <= 3'h7;
		end else begin
			scl_reg <= {scl_reg[1:0], scl_in};
			sda_reg <= {sda_reg[1:0], sda_in};
		end
	end

	// only stages 1 and 2 are looked at, stage 0 may be metastable
	assign rise_out = scl_reg[1] & ~scl_reg[2];
	assign fall_out = ~scl_reg[1] & scl_reg[2];
	assign start_out = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
	assign stop_out = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];
	assign sda_out = sda_reg[1];
endmodule
`default_nettype wire

// ==== verification/broadcast_device_control_ccc_decoder_assertions.sv ====
// checker for the decoder's result pulses and ack drive
`timescale 1ns/10ps
`default_nettype none
module broadcast_device_control_ccc_checker (
	input wire logic sys_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset
	input wire logic sda_out, // data drive level
	input wire logic sda_oe_out, // data drive enable
	input wire logic i3c_mode_in, // bus mode
	input wire logic pec_enable_in, // checksum enable
	input wire logic [31:0] data_out, // payload bytes
	input wire logic [3:0] byte_en_out, // payload valid
	input wire logic commit_out, // accepted pulse
	input wire logic parity_err_out, // parity pulse
	input wire logic pec_err_out // checksum pulse
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	//----------------------------------------
	// properties
	//----------------------------------------
	a_ack_drives_low: assert property (sda_oe_out |-> !sda_out)
		else $error("ack drives high");
	a_commit_one_cycle: assert property (commit_out |=> !commit_out)
		else $error("commit longer than one cycle");
	a_perr_one_cycle: assert property (parity_err_out |=> !parity_err_out)
		else $error("parity pulse too long");
	a_pec_one_cycle: assert property (pec_err_out |=> !pec_err_out)
		else $error("checksum pulse too long");
	a_commit_no_error: assert property (commit_out |->
		!(parity_err_out || pec_err_out)) else $error("commit with error");
	a_pec_i3c_only: assert property (pec_err_out |->
		i3c_mode_in && pec_enable_in) else $error("checksum error in i2c");
	a_data_held: assert property ($changed(data_out) ||
		$changed(byte_en_out) |-> commit_out || $past(commit_out))
		else $error("payload changed without commit");
	a_commit_bytes: assert property (commit_out |->
		##[0:1] byte_en_out != 4'h0) else $error("commit with no bytes");
	a_ack_slot: assert property ($rose(sda_oe_out) |->
		sda_oe_out [*4] ##[1:12] !sda_oe_out) else $error("ack slot length");
	// main outcomes seen
	c_commit: cover property (commit_out);
	c_perr: cover property (parity_err_out);
	c_pecerr: cover property (pec_err_out);
	c_ack_i3c: cover property ($rose(sda_oe_out) && i3c_mode_in);
endmodule
`default_nettype wire

// ==== verification/bus_host_model.sv ====
// host model driving bus clock and open-drain data
`timescale 1ns/10ps
`default_nettype none
module bus_host_model (
	input wire logic clk_in, // timing reference
	input wire logic dev_oe_in, // device pulls data low
	output logic scl_out, // bus clock, idles high
	output logic sda_out // resolved data wire
);
	logic drv_low = 1'b0;
	// pull-up wins unless someone pulls low
	assign sda_out = !(drv_low || dev_oe_in);
	initial scl_out = 1'b1;
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// start, or repeat start when clock is low
	task automatic start();
		drv_low = 1'b0;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		drv_low = 1'b1;
		wt(4);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		wt(2);
		drv_low = 1'b1;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		drv_low = 1'b0;
		wt(4);
	endtask
	// 320 ns bit: 3.125 MHz, above the 1 MHz i2c rate limit
	task automatic send_bit(input logic b, output logic seen);
		wt(2);
		drv_low = !b;
		wt(2);
		scl_out = 1'b1;
		wt(2);
		seen = sda_out;
		wt(2);
		scl_out = 1'b0;
	endtask
	// msb first, then the ninth bit; only volatile traffic
	task automatic send_byte(input logic [7:0] b, input logic t,
			output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			send_bit(b[i], s);
		send_bit(t, s);
		ack = !s;
	endtask
endmodule
`default_nettype wire

// ==== verification/broadcast_device_control_ccc_tb.sv ====
// self-checking bench for the broadcast device-control decoder
`timescale 1ns/10ps
`default_nettype none
module broadcast_device_control_ccc_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b0;
	logic pec_en = 1'b0;
	logic par_en = 1'b1;
	logic scl;
	logic sda;
	logic sda_drv;
	logic oe;
	logic commit;
	logic perr;
	logic pecerr;
	logic devspec;
	logic [31:0] data;
	logic [3:0] ben;
	logic last_ack;
	int mismatches = 0;
	int total_checks = 0;
	int n_com = 0;
	int n_per = 0;
	int n_pec = 0;
	initial forever #20 clk = ~clk;
	// the device pulls low only when enabled and its level is low
	bus_host_model bus_host_model_i (.clk_in(clk),
		.dev_oe_in(oe && !sda_drv), .scl_out(scl), .sda_out(sda));
	// own code 7'h4d
	broadcast_device_control_ccc broadcast_device_control_ccc_i (
		.sys_clk_in(clk), .sys_rst_in(rst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(oe),
		.i3c_mode_in(mode), .pec_enable_in(pec_en),
		.parity_enable_in(par_en),
		.local_type_id_in(4'h9), .host_slot_id_in(3'h5), .data_out(data),
		.byte_en_out(ben), .devspec_out(devspec), .commit_out(commit),
		.parity_err_out(perr), .pec_err_out(pecerr));
	// tally pulses so a doubled pulse is seen too
	always @(posedge clk) begin
		n_com <= n_com + int'(commit === 1'b1);
		n_per <= n_per + int'(perr === 1'b1);
		n_pec <= n_pec + int'(pecerr === 1'b1);
	end
	task automatic check(input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, b);
		c = c ^ b;
		repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction
	// one frame; exp nibbles are ack, commits, parity and checksum errors
	task automatic run(input logic [7:0] sel, tgt, input int n,
			input logic [31:0] d, input int pec, bad, input logic stp,
			input logic [15:0] exp);
		logic [7:0] q [0:6];
		logic [7:0] c;
		logic a;
		int len;
		int c0;
		int p0;
		int e0;
		c = 8'h00;
		c0 = n_com;
		p0 = n_per;
		e0 = n_pec;
		q[0] = sel;
		q[1] = tgt;
		for (int i = 0; i < n; i++)
			q[i + 2] = d[8*i +: 8];
		len = n + 2;
		// broadcast address stays out of the checksum
		for (int i = 0; i < len; i++)
			c = crc8(c, q[i]);
		if (pec > 0) begin
			q[len] = c ^ {8{pec == 2}};
			len++;
		end
		bus_host_model_i.start();
		bus_host_model_i.send_byte(8'hfc, 1'b1, last_ack);
		for (int i = 0; i < len; i++)
			bus_host_model_i.send_byte(q[i], ~^q[i] ^ (i == bad), a);
		if (stp)
			bus_host_model_i.stop();
		bus_host_model_i.wt(8);
		check({19'h0, last_ack, 4'(n_com - c0), 4'(n_per - p0),
			4'(n_pec - e0)}, {16'h0, exp});
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		run(8'he8, 8'h00, 2, 32'h3ca5, 0, -1, 1, 16'h1100);
		check(data & 32'h00ffff00, 32'h003ca500);
		check({28'h0, ben}, 32'h6);
		run(8'h00, 8'h9a, 1, 32'h11, 0, -1, 1, 16'h1100);
		run(8'h00, 8'h9c, 2, 32'h2211, 0, 3, 1, 16'h1010);
		run(8'h60, 8'h94, 1, 32'h22, 0, -1, 1, 16'h1100);
		run(8'h20, 8'h9a, 1, 32'h33, 0, -1, 1, 16'h1000);
		run(8'hff, 8'h00, 1, 32'h77, 0, -1, 1, 16'h1100);
		check({19'h0, devspec, ben, data[7:0]}, 32'h1177);
		run(8'h00, 8'h9a, 1, 32'h44, 0, 2, 0, 16'h1010);
		run(8'he8, 8'h00, 1, 32'h01, 0, -1, 1, 16'h0000);
		// parity checking off: a bad T bit must not stop the commit
		par_en = 1'b0;
		run(8'h00, 8'h9a, 1, 32'h55, 0, 2, 1, 16'h1100);
		par_en = 1'b1;
		mode = 1'b1;
		pec_en = 1'b1;
		run(8'he2, 8'h00, 2, 32'hbbaa, 1, -1, 1, 16'h1100);
		check(data & 32'hffff, 32'hbbaa);
		// device space: index and burst fields ignored, checksum after two
		run(8'h19, 8'h9a, 2, 32'h1234, 1, -1, 1, 16'h1100);
		check({16'h0, data[15:0]}, 32'h1234);
		run(8'he2, 8'h00, 2, 32'h99, 2, -1, 0, 16'h1001);
		run(8'he8, 8'h00, 1, 32'h01, 0, -1, 1, 16'h0000);
		run(8'h02, 8'h9a, 2, 32'h5566, 1, 1, 1, 16'h1010);
		mode = 1'b0;
		run(8'he2, 8'h00, 2, 32'h5566, 0, -1, 1, 16'h1100);
		report_and_stop();
	end
endmodule
bind broadcast_device_control_ccc broadcast_device_control_ccc_checker chk_i (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .i3c_mode_in(i3c_mode_in),
	.pec_enable_in(pec_enable_in), .data_out(data_out),
	.byte_en_out(byte_en_out), .commit_out(commit_out),
	.parity_err_out(parity_err_out), .pec_err_out(pec_err_out));
`default_nettype wire
